// file: logic/epd_regs.svh
// Register offsets, field positions, reset values and timing counts of
// the engine power derating manager.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef EPD_REGS_SVH
`define EPD_REGS_SVH
// =====================================================================
// Timing
// =====================================================================
`define EPD_CLK_NS 25
`define EPD_MS_NS 1000000
`define EPD_SEC_NS 1000000000
`define EPD_MS_CYCLES (`EPD_MS_NS / `EPD_CLK_NS)
`define EPD_SEC_CYCLES (`EPD_SEC_NS / `EPD_CLK_NS)
`define EPD_PCT_FULL 100
// =====================================================================
// Register map (byte offsets)
// =====================================================================
`define EPD_STEP_STRIDE 8'h10
`define EPD_OFS_PCT 4'h0
`define EPD_OFS_RATE 4'h4
`define EPD_OFS_HOLD 4'h8
`define EPD_OFS_OPT 4'hc
`define EPD_OFS_STATUS 8'h40
`define EPD_OFS_MASK 8'h44
`define EPD_OFS_SETPT 8'h48
`define EPD_OFS_STATE 8'h4c
// =====================================================================
// Fields and reset values
// =====================================================================
`define EPD_OPT_NOMINAL 0
`define EPD_OPT_FULL 1
`define EPD_ST_ON 0
`define EPD_ST_OFF 1
`define EPD_RST_PCT 8'h00
`define EPD_RST_RATE 8'h0a
`define EPD_RST_HOLD 16'h0000
`define EPD_RST_OPT 2'h0
`endif

// file: logic/epd_pkg.sv
// Types shared by the engine power derating manager.
// Assumes nothing beyond a SystemVerilog compiler.
package epd_pkg;
  // Power value in plant units (same scale as nominal power).
  typedef logic [15:0] epd_power_t;
  // Percentage or percent per second.
  typedef logic [7:0] epd_pct_t;
  // Configuration of one derating step.
  typedef struct packed {
    epd_pct_t pct;
    epd_pct_t rate;
    logic [15:0] hold;
    logic [1:0] opt;
  } epd_step_cfg_t;
endpackage

// file: logic/epd_ramp_if.sv
// Signals between the derating selector and the setpoint ramp.
// Assumes both ends run on the same clock.
interface epd_ramp_if;
  import epd_pkg::*;
  epd_power_t target; // Setpoint to ramp toward.
  epd_pct_t rate; // Ramp rate in percent of nominal per second.
  epd_power_t nominal; // Nominal power, scale of the rate.
  epd_power_t current; // Present ramped setpoint.
  modport ctrl (output target, output rate, output nominal, input current);
  modport ramp (input target, input rate, input nominal, output current);
endinterface

// file: logic/epd_ramp.sv
// Setpoint ramp: moves the present setpoint toward a target at a rate
// given in percent of nominal power per second.
// Assumes one clock; the target may change at any cycle.
`include "epd_regs.svh"
module epd_ramp
  import epd_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `EPD_SEC_CYCLES
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  epd_ramp_if.ramp rp
);
  // One unit of movement is due each time the accumulator passes
  // 100 percent times one second of cycles.
  localparam logic [39:0] THR = 40'(SEC_CYCLES) * 40'(`EPD_PCT_FULL);
  logic [39:0] acc; // Fractional progress toward the next unit.
  logic [39:0] next_acc;
  epd_power_t cur; // Present setpoint.
  epd_power_t next_cur;
  // =====================================================================
  // Ramp step
  // =====================================================================
  // Adds rate times nominal on each cycle that neither takes a step nor sits
  // at target, so at most one unit moves per cycle, whatever the rate and nominal.
  always_comb
  begin
    next_acc = acc;
    next_cur = cur;
    if (cur == rp.target)
    begin
      next_acc = '0; // At target, no partial step carries over.
    end
    else if (acc >= THR)
    begin
      next_acc = acc - THR;
      // Gradual movement, one unit at a time.
      if (rp.target > cur) next_cur = cur + 16'h0001;
      else next_cur = cur - 16'h0001;
    end
    else
    begin
      next_acc = acc + 40'(rp.rate) * 40'(rp.nominal);
    end
  end
  // Registers the ramp state; the setpoint starts at zero.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      acc <= '0;
      cur <= '0;
    end
    else
    begin
      acc <= next_acc;
      cur <= next_cur;
    end
  end
  assign rp.current = cur;
  a_ramp_unit_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cur - $past(cur) <= 16'h0001) || ($past(cur) - cur <= 16'h0001))
    else $error("setpoint moved more than one unit per cycle");
  a_ramp_no_overshoot: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cur < rp.target) && $stable(rp.target) |=> cur <= $past(rp.target))
    else $error("ramp overshot its target");
endmodule

// file: logic/epd_top.sv
// Engine power derating manager: four request inputs, per-step config,
// governing selection, setpoint ramp, events and interrupt.
// Assumes request inputs are asynchronous pins and the power inputs
// come from logic on core_clk.
`include "epd_regs.svh"
module epd_top
  import epd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `EPD_MS_CYCLES,
  parameter int unsigned SEC_CYCLES = `EPD_SEC_CYCLES,
  parameter int unsigned STEPS = 4
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic derate_request_1,
  input wire logic derate_request_2,
  input wire logic derate_request_3,
  input wire logic derate_request_4,
  input wire epd_pkg::epd_power_t base_setpoint,
  input wire epd_pkg::epd_power_t nominal_power,
  input wire epd_pkg::epd_power_t measured_power,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output epd_pkg::epd_power_t active_setpoint,
  output epd_pkg::epd_power_t broadcast_power,
  output logic derate_on_event,
  output logic derate_all_off_event,
  output logic irq
);
  import epd_pkg::*;
  // =====================================================================
  // Declarations
  // =====================================================================
  logic [STEPS-1:0] req_pin; // Raw request pins.
  logic [STEPS-1:0] req; // Filtered request levels.
  logic [STEPS-1:0] req_d; // Request levels one cycle earlier.
  logic [STEPS-1:0] rise; // Inactive-to-active transitions.
  logic [STEPS-1:0] fall; // Active-to-inactive transitions.
  epd_step_cfg_t cfg [STEPS]; // Per-step configuration.
  epd_step_cfg_t next_cfg [STEPS];
  epd_power_t amt [STEPS]; // Reduction latched at activation.
  epd_power_t next_amt [STEPS];
  epd_power_t calc_amt [STEPS]; // Reduction computed from live inputs.
  logic [15:0] hold [STEPS]; // Remaining hold time in ms.
  logic [15:0] next_hold [STEPS];
  logic [STEPS-1:0] finish; // Full ramp still owed.
  logic [STEPS-1:0] next_finish;
  logic [STEPS-1:0] engaged; // Step contributes to selection.
  logic [1:0] gov; // Governing step index.
  logic gov_any; // Some step is engaged.
  logic [1:0] last_gov; // Step that governed most recently.
  logic [1:0] next_last_gov;
  logic [31:0] tick_cnt; // Millisecond tick divider.
  logic [31:0] next_tick_cnt;
  logic tick; // One-cycle millisecond tick.
  logic [1:0] status; // Sticky event bits.
  logic [1:0] next_status;
  logic [1:0] mask; // Interrupt mask.
  logic [1:0] next_mask;
  logic [31:0] next_rdata;
  epd_power_t next_setpoint;
  logic next_on;
  logic next_off;
  epd_ramp_if rp ();

  // Saturating subtraction so a reduction never goes below zero.
  function automatic epd_power_t sat_sub(epd_power_t a, epd_power_t b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction

  assign req_pin = {derate_request_4, derate_request_3,
                    derate_request_2, derate_request_1};

  // =====================================================================
  // Input synchronisers
  // =====================================================================
  // Three shift flops per pin; a change is taken only once the second and
  // third agree, which rejects a one-sample glitch.
  for (genvar g = 0; g < STEPS; g++)
  begin : g_sync
    logic [2:0] s; // Shift chain; s[0] feeds only s[1].
    logic lvl; // Accepted level of this pin.
    // A local flop per pin keeps each bit of req with a single driver.
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        s <= 3'h0;
        lvl <= 1'b0;
      end
      else
      begin
        s <= {s[1:0], req_pin[g]};
        if (s[1] == s[2]) lvl <= s[2];
      end
    end
    assign req[g] = lvl;
  end

  // Registered previous level gives exactly one rise per activation.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) req_d <= '0;
    else req_d <= req;
  end
  assign rise = req & ~req_d;
  assign fall = ~req & req_d;

  // =====================================================================
  // Millisecond tick
  // =====================================================================
  always_comb
  begin
    tick = (tick_cnt == MS_CYCLES - 1);
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) tick_cnt <= 32'h0;
    else tick_cnt <= next_tick_cnt;
  end

  // =====================================================================
  // Per-step state: reduction, hold timer, owed full ramp
  // =====================================================================
  // The base of the percentage is chosen per step; the measured power
  // is sampled only at activation, so later load changes do not move it.
  always_comb
  begin
    for (int i = 0; i < STEPS; i++)
    begin
      calc_amt[i] = 16'((24'(cfg[i].opt[`EPD_OPT_NOMINAL] ? nominal_power
                    : measured_power) * 24'(cfg[i].pct))
                    / 24'(`EPD_PCT_FULL));
      next_amt[i] = rise[i] ? calc_amt[i] : amt[i];
      if (req[i]) next_hold[i] = 16'h0;
      else if (fall[i]) next_hold[i] = cfg[i].hold;
      else if (tick && hold[i] != 16'h0) next_hold[i] = hold[i] - 16'h1;
      else next_hold[i] = hold[i];
      if (rise[i]) next_finish[i] = cfg[i].opt[`EPD_OPT_FULL];
      else if (rp.current <= sat_sub(base_setpoint, amt[i]))
        next_finish[i] = 1'b0;
      else next_finish[i] = finish[i];
      engaged[i] = req[i] || hold[i] != 16'h0 || finish[i];
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      finish <= '0;
      for (int i = 0; i < STEPS; i++)
      begin
        amt[i] <= 16'h0;
        hold[i] <= 16'h0;
      end
    end
    else
    begin
      finish <= next_finish;
      amt <= next_amt;
      hold <= next_hold;
    end
  end

  // =====================================================================
  // Governing selection and ramp target
  // =====================================================================
  // Ties go to the lower-numbered step; the result is the same target.
  always_comb
  begin
    gov = 2'h0;
    gov_any = 1'b0;
    for (int i = 0; i < STEPS; i++)
    begin
      if (engaged[i] && (!gov_any || amt[i] > amt[gov]))
      begin
        gov = 2'(i);
        gov_any = 1'b1;
      end
    end
    next_last_gov = gov_any ? gov : last_gov;
    // Never above the pre-derating setpoint.
    rp.target = gov_any ? sat_sub(base_setpoint, amt[gov])
                : base_setpoint;
    rp.rate = cfg[gov_any ? gov : last_gov].rate;
    rp.nominal = nominal_power;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) last_gov <= 2'h0;
    else last_gov <= next_last_gov;
  end

  epd_ramp #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_ramp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rp(rp)
  );

  // =====================================================================
  // Outputs, events and register file
  // =====================================================================
  // Set wins over a same-cycle write-one-to-clear.
  always_comb
  begin
    next_setpoint = rp.current;
    next_on = |rise;
    next_off = (|req_d) && !(|req);
    next_cfg = cfg;
    next_mask = mask;
    next_status = status;
    next_rdata = 32'h0;
    if (reg_wr && reg_addr < `EPD_OFS_STATUS)
    begin
      case (reg_addr[3:0])
        `EPD_OFS_PCT: next_cfg[reg_addr[5:4]].pct = reg_wdata[7:0];
        `EPD_OFS_RATE: next_cfg[reg_addr[5:4]].rate = reg_wdata[7:0];
        `EPD_OFS_HOLD: next_cfg[reg_addr[5:4]].hold = reg_wdata[15:0];
        `EPD_OFS_OPT: next_cfg[reg_addr[5:4]].opt = reg_wdata[1:0];
        default: next_cfg = cfg;
      endcase
    end
    if (reg_wr && reg_addr == `EPD_OFS_STATUS)
      next_status = status & ~reg_wdata[1:0];
    if (reg_wr && reg_addr == `EPD_OFS_MASK) next_mask = reg_wdata[1:0];
    next_status[`EPD_ST_ON] = next_status[`EPD_ST_ON] | next_on;
    next_status[`EPD_ST_OFF] = next_status[`EPD_ST_OFF] | next_off;
    if (reg_rd)
    begin
      if (reg_addr < `EPD_OFS_STATUS)
      begin
        case (reg_addr[3:0])
          `EPD_OFS_PCT: next_rdata = {24'h0, cfg[reg_addr[5:4]].pct};
          `EPD_OFS_RATE: next_rdata = {24'h0, cfg[reg_addr[5:4]].rate};
          `EPD_OFS_HOLD: next_rdata = {16'h0, cfg[reg_addr[5:4]].hold};
          `EPD_OFS_OPT: next_rdata = {30'h0, cfg[reg_addr[5:4]].opt};
          default: next_rdata = 32'h0;
        endcase
      end
      else
      begin
        case (reg_addr)
          `EPD_OFS_STATUS: next_rdata = {30'h0, status};
          `EPD_OFS_MASK: next_rdata = {30'h0, mask};
          `EPD_OFS_SETPT: next_rdata = {16'h0, rp.current};
          `EPD_OFS_STATE: next_rdata = {17'h0, gov_any, gov, finish,
                                        engaged, req};
          default: next_rdata = 32'h0;
        endcase
      end
    end
  end
  // Registers outputs so every port comes straight from a flop.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < STEPS; i++)
        cfg[i] <= '{`EPD_RST_PCT, `EPD_RST_RATE, `EPD_RST_HOLD, `EPD_RST_OPT};
      status <= 2'h0;
      mask <= 2'h0;
      reg_rdata <= 32'h0;
      active_setpoint <= 16'h0;
      broadcast_power <= 16'h0;
      derate_on_event <= 1'b0;
      derate_all_off_event <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      active_setpoint <= next_setpoint;
      broadcast_power <= next_setpoint;
      derate_on_event <= next_on;
      derate_all_off_event <= next_off;
      irq <= |(next_status & next_mask);
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  a_on_event_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    (|rise) |=> derate_on_event && status[`EPD_ST_ON])
    else $error("activation did not raise the on event");
  a_all_off_event: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(|req) |=> derate_all_off_event)
    else $error("release of last request gave no off event");
  a_rise_single: assert property (@(posedge core_clk) disable iff (sys_rst)
    (|rise) |=> ((rise & $past(rise)) == '0))
    else $error("one activation gave two rises");
  a_amt_latched: assert property (@(posedge core_clk) disable iff (sys_rst)
    rise[0] |=> amt[0] == $past(calc_amt[0]) ##1 $stable(amt[0]))
    else $error("reduction not taken at activation");
  a_gov_largest: assert property (@(posedge core_clk) disable iff (sys_rst)
    gov_any |-> engaged[gov]
                && !(engaged[0] && amt[0] > amt[gov])
                && !(engaged[1] && amt[1] > amt[gov])
                && !(engaged[2] && amt[2] > amt[gov])
                && !(engaged[3] && amt[3] > amt[gov]))
    else $error("governing step is not the largest");
  a_hold_engaged: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(req[0]) && cfg[0].hold != 16'h0 |=> engaged[0][*3])
    else $error("hold time did not keep the step engaged");
  a_target_below: assert property (@(posedge core_clk) disable iff (sys_rst)
    rp.target <= base_setpoint)
    else $error("ramp target above pre-derating setpoint");
  a_broadcast_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 broadcast_power == active_setpoint)
    else $error("broadcast power differs from derated setpoint");
  a_finish_owed: assert property (@(posedge core_clk) disable iff (sys_rst)
    finish[0] |-> engaged[0])
    else $error("owed full ramp left the step disengaged");
endmodule

// file: bench/epd_peer_model.sv
// Peer generator controller as seen across the sharing bus.
// Assumes the published size arrives registered on core_clk.
module epd_peer_model
  import epd_pkg::*;
#(
  parameter int unsigned PEER_NOMINAL = 1000
)
(
  input wire logic core_clk,
  input wire epd_pkg::epd_power_t broadcast_power,
  input wire logic [15:0] plant_load,
  output logic [15:0] peer_share
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================================
  // Load sharing
  // ====================================================================
  // The peer splits the plant load by published sizes, so a derated unit
  // is treated as a smaller machine. The peer size is never zero, which
  // keeps the divisor safe.
  always_ff @(posedge core_clk)
  begin
    peer_share <= 16'((32'(plant_load) * PEER_NOMINAL) /
      (32'(broadcast_power) + PEER_NOMINAL));
  end
endmodule

// file: bench/epd_top_tb.sv
// Self-checking bench for the engine power derating manager.
// Assumes the design and peer model files are compiled before it.
module epd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import epd_pkg::*;
  // ====================================================================
  // Stimulus and observation
  // ====================================================================
  // Short counts keep the hold and ramp times small.
  localparam int unsigned MS_C = 4;
  localparam int unsigned SEC_C = 1000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:1] req = 4'h0;
  epd_power_t base_sp = 16'h03e8;
  epd_power_t nom = 16'h03e8;
  epd_power_t meas = 16'h01f4;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  epd_power_t active_setpoint;
  epd_power_t broadcast_power;
  logic derate_on_event;
  logic derate_all_off_event;
  logic irq;
  logic [15:0] plant_load = 16'h0640;
  logic [15:0] peer_share;
  int n_fail = 0;
  int num_checks = 0;
  int n_on = 0;
  int n_off = 0;
  logic [31:0] d;

  always #12.5 core_clk = ~core_clk;

  epd_top #(.MS_CYCLES(MS_C), .SEC_CYCLES(SEC_C), .STEPS(4)) u_epd_top
  (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .derate_request_1(req[1]), .derate_request_2(req[2]),
    .derate_request_3(req[3]), .derate_request_4(req[4]),
    .base_setpoint(base_sp), .nominal_power(nom), .measured_power(meas),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_setpoint(active_setpoint), .broadcast_power(broadcast_power),
    .derate_on_event(derate_on_event),
    .derate_all_off_event(derate_all_off_event), .irq(irq)
  );

  epd_peer_model #(.PEER_NOMINAL(1000)) u_epd_peer_model
  (
    .core_clk(core_clk), .broadcast_power(broadcast_power),
    .plant_load(plant_load), .peer_share(peer_share)
  );

  // Events are single-cycle pulses, so they are counted on every edge.
  always @(posedge core_clk)
  begin
    if (derate_on_event === 1'b1)
      n_on <= n_on + 1;
    if (derate_all_off_event === 1'b1)
      n_off <= n_off + 1;
  end

  // ====================================================================
  // Shared tasks
  // ====================================================================
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic pin(input int n, input logic v);
    @(posedge core_clk);
    req[n] <= v;
  endtask

  task automatic wait_on(input int exp);
    for (int i = 0; i < 12 && n_on != exp; i++)
      @(posedge core_clk);
    check(32'(n_on), 32'(exp));
  endtask

  // Follows the ramp; a jump of more than one unit is a fault.
  task automatic wait_set(input epd_power_t exp, input int max_cyc);
    epd_power_t prev;
    epd_power_t diff;
    prev = active_setpoint;
    for (int i = 0; i < max_cyc && active_setpoint !== exp; i++)
    begin
      @(posedge core_clk);
      #1;
      diff = active_setpoint - prev;
      check(32'(diff inside {16'h0000, 16'h0001, 16'hffff}), 32'h1);
      check(32'(broadcast_power), 32'(active_setpoint));
      prev = active_setpoint;
    end
    check(32'(active_setpoint), 32'(exp));
  endtask

  // ====================================================================
  // Scenarios
  // ====================================================================
  task automatic t_reset();
    logic [31:0] rv [4];
    rv = '{32'h0, 32'h0a, 32'h0, 32'h0};
    for (int k = 0; k < 4; k++)
    begin
      rd(8'(4 * k), d);
      check(d, rv[k]);
    end
    rd(8'h80, d);
    check(d, 32'h0);
    check(32'(irq), 32'h0);
  endtask

  // Step n belongs to request n+1; read-back proves four separate sets.
  task automatic t_config();
    logic [31:0] cfg [4][4];
    cfg = '{'{10, 100, 10, 1}, '{20, 100, 0, 0},
      '{30, 100, 0, 3}, '{40, 50, 0, 1}};
    for (int n = 0; n < 4; n++)
      for (int k = 0; k < 4; k++)
        wr(8'(16 * n + 4 * k), cfg[n][k]);
    for (int n = 0; n < 4; n++)
      for (int k = 0; k < 4; k++)
      begin
        rd(8'(16 * n + 4 * k), d);
        check(d, cfg[n][k]);
      end
    wait_set(16'h03e8, 2000);
    rd(8'h48, d);
    check(d, 32'h3e8);
  endtask

  task automatic t_select_irq();
    pin(1, 1'b1);
    wait_on(1);
    rd(8'h40, d);
    check(d, 32'h1);
    check(32'(irq), 32'h0);
    wait_set(16'h0384, 400);
    pin(4, 1'b1);
    wait_on(2);
    wait_set(16'h0258, 1200);
    repeat (2) @(posedge core_clk);
    check(32'(peer_share), 32'h3e8);
    pin(4, 1'b0);
    wait_set(16'h0384, 700);
    wr(8'h44, 32'h3);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h1);
    wr(8'h40, 32'h1);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h0);
    pin(1, 1'b0);
    repeat (8) @(posedge core_clk);
    check(32'(n_off), 32'h1);
    rd(8'h40, d);
    check(d, 32'h2);
    check(32'(irq), 32'h1);
    repeat (10) @(posedge core_clk);
    check(32'(active_setpoint), 32'h384);
    wait_set(16'h03e8, 400);
    wr(8'h40, 32'h2);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h0);
  endtask

  // Base is the power seen at activation; later changes do not count.
  task automatic t_measured();
    pin(2, 1'b1);
    wait_on(3);
    meas <= 16'h012c;
    wait_set(16'h0384, 400);
    repeat (20) @(posedge core_clk);
    check(32'(active_setpoint), 32'h384);
    pin(2, 1'b0);
    wait_set(16'h03e8, 400);
  endtask

  // A short press on a full-ramp step still reaches the full reduction.
  task automatic t_full_ramp();
    pin(3, 1'b1);
    repeat (6) @(posedge core_clk);
    req[3] <= 1'b0;
    wait_on(4);
    wait_set(16'h02bc, 700);
    check(32'(n_on), 32'h4);
    wait_set(16'h03e8, 700);
  endtask

  // ====================================================================
  // Main sequence and watchdog
  // ====================================================================
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_config();
    t_select_irq();
    t_measured();
    t_full_ramp();
    close_out();
  end

  // The sequence needs well under 10000 cycles; twice that means a hang.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out();
  end
endmodule
